// [design/audio_link_pkg.sv]
// constants and helpers shared by both ends of the eight-channel serial audio link
// assumes one 50 MHz core clock per end and a link of clock, frame marker and data
//
// Behaviour
// RULE1 - eight channels one way, 26- or 32-bit words
// RULE2 - frame rate between 28k and 54k per second
// RULE3 - order: left A-D as 0-3, right A-D as 4-7
// RULE4 - each pair may be mono, slots unchanged
// RULE5 - bit clock is 208x or 256x frame rate
// RULE6 - one-cycle marker, channel 0 MSB next cycle
// RULE7 - samples sent MSB first, two's complement
// RULE8 - unused low bits of a slot sent as zero
// RULE9 - receiver tells format by 208 or 256 count
// RULE10 - sender changes marker and data on falling edge
// RULE11 - receiver samples marker and data on rising edge
// RULE12 - clock, marker and data from one device's flops
// RULE13 - other interval counts mean misalignment, frames dropped
package audio_link_pkg;

    localparam int unsigned CHANNELS          = 8;
    localparam int unsigned SLOT_BITS         = 32;
    localparam int unsigned FRAME_BITS        = CHANNELS * SLOT_BITS;
    localparam int unsigned NARROW_WORD_BITS  = 26;
    localparam int unsigned WIDE_WORD_BITS    = 32;
    localparam int unsigned NARROW_FRAME_BITS = CHANNELS * NARROW_WORD_BITS;

    localparam logic [8:0] NARROW_FRAME_CLKS = 9'h0D0;
    localparam logic [8:0] WIDE_FRAME_CLKS   = 9'h100;
    localparam logic [8:0] COUNT_SATURATE    = 9'h1FF;
    localparam logic [4:0] NARROW_LAST_BIT   = 5'h19;
    localparam logic [4:0] WIDE_LAST_BIT     = 5'h1F;
    localparam logic [2:0] FIRST_CHANNEL     = 3'h0;
    localparam logic [2:0] LAST_CHANNEL      = 3'h7;
    localparam logic [5:0] FULL_SLOT_BITS    = 6'h20;

    localparam int unsigned CORE_CLK_HZ        = 50_000_000;
    localparam int unsigned CORE_CLK_PERIOD_NS = 20;
    localparam int unsigned LINK_MIN_PHASE_NS  = 32;
    localparam int unsigned FRAME_RATE_MIN_HZ  = 28_000;
    localparam int unsigned FRAME_RATE_MAX_HZ  = 54_000;
    localparam int unsigned LINK_MIN_PHASE_CYCLES =
        (LINK_MIN_PHASE_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
    // half period chosen so the frame rate stays under the maximum
    // one link clock per bit, so clocks per frame equal bits per frame
    localparam int unsigned NARROW_HALF_RAW =
        (CORE_CLK_HZ + 2 * NARROW_FRAME_BITS * FRAME_RATE_MAX_HZ - 1) /
        (2 * NARROW_FRAME_BITS * FRAME_RATE_MAX_HZ);
    localparam int unsigned WIDE_HALF_RAW =
        (CORE_CLK_HZ + 2 * FRAME_BITS * FRAME_RATE_MAX_HZ - 1) /
        (2 * FRAME_BITS * FRAME_RATE_MAX_HZ);
    localparam int unsigned NARROW_HALF_CYCLES =
        (NARROW_HALF_RAW > LINK_MIN_PHASE_CYCLES) ? NARROW_HALF_RAW : LINK_MIN_PHASE_CYCLES;
    localparam int unsigned WIDE_HALF_CYCLES =
        (WIDE_HALF_RAW > LINK_MIN_PHASE_CYCLES) ? WIDE_HALF_RAW : LINK_MIN_PHASE_CYCLES;

    function automatic logic [4:0] word_last_bit(input logic wide);
        return wide ? WIDE_LAST_BIT : NARROW_LAST_BIT;
    endfunction

    // bits == 0 or >= 32 keeps the whole slot
    function automatic logic [SLOT_BITS-1:0] zero_fill_mask(input logic [5:0] bits);
        logic [SLOT_BITS-1:0] m;
        m = '1;
        if (bits != 6'h00 && bits < FULL_SLOT_BITS) begin
            m = ~({SLOT_BITS{1'b1}} >> bits);
        end
        return m;
    endfunction

    // serial image to slots: channel c at [c*32 +: 32], left justified
    function automatic logic [FRAME_BITS-1:0] unpack_frame(
        input logic [FRAME_BITS-1:0] sr,
        input logic                  wide
    );
        logic [FRAME_BITS-1:0] f;
        f = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            if (wide) begin
                f[c*SLOT_BITS +: SLOT_BITS] = sr[FRAME_BITS-1-c*SLOT_BITS -: SLOT_BITS];
            end else begin
                f[c*SLOT_BITS +: SLOT_BITS] =
                    {sr[NARROW_FRAME_BITS-1-c*NARROW_WORD_BITS -: NARROW_WORD_BITS],
                     {(SLOT_BITS-NARROW_WORD_BITS){1'b0}}};
            end
        end
        return f;
    endfunction

endpackage

// [design/audio_link_if.sv]
// the three link lines between sender and receiver
// assumes the testbench instantiates it and joins both ends
`timescale 1ns/1ns
`default_nettype none
interface audio_link_if;
    logic link_bit_clock;
    logic frame_marker;
    logic serial_audio_line;

    modport sender (
        output link_bit_clock,
        output frame_marker,
        output serial_audio_line
    );
    modport receiver (
        input  link_bit_clock,
        input  frame_marker,
        input  serial_audio_line
    );
endinterface
`default_nettype wire

// [design/audio_link_sender.sv]
// sending end: takes whole frames of eight slots and serialises them
// assumes the user side runs on core_clk_i; the link clock is made here
`timescale 1ns/1ns
`default_nettype none
module audio_link_sender
    import audio_link_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    audio_link_if.sender               link,
    input  wire logic                  in_valid_i,
    output logic                       in_ready_o,
    input  wire logic [FRAME_BITS-1:0] in_frame_i,
    input  wire logic                  in_wide_i,
    input  wire logic [5:0]            in_sample_bits_i
);

    typedef struct packed {
        logic [7:0]            div;
        logic                  clk;
        logic                  marker;
        logic                  data;
        logic [2:0]            chan;
        logic [4:0]            bitn;
        logic                  wide;
        logic [FRAME_BITS-1:0] cur;
        logic [FRAME_BITS-1:0] head;
        logic                  head_wide;
        logic                  head_v;
        logic [FRAME_BITS-1:0] skid;
        logic                  skid_wide;
        logic                  skid_v;
        logic                  ready;
    } tx_state_t;

    // parked at the last bit so the first falling edge sends a marker
    localparam tx_state_t TX_RESET = '{
        div: 8'h00, clk: 1'b0, marker: 1'b0, data: 1'b0,
        chan: LAST_CHANNEL, bitn: NARROW_LAST_BIT, wide: 1'b0,
        cur: '0, head: '0, head_wide: 1'b0, head_v: 1'b0,
        skid: '0, skid_wide: 1'b0, skid_v: 1'b0, ready: 1'b0};
    localparam logic [7:0] NARROW_HALF_LAST = 8'(NARROW_HALF_CYCLES - 1);
    localparam logic [7:0] WIDE_HALF_LAST   = 8'(WIDE_HALF_CYCLES - 1);

    tx_state_t s;
    tx_state_t next_s;

    always_comb begin
        logic                  take;
        logic                  last_slot_bit;
        logic [7:0]            half_last;
        logic [FRAME_BITS-1:0] masked;
        next_s        = s;
        take          = in_valid_i && s.ready;
        half_last     = s.wide ? WIDE_HALF_LAST : NARROW_HALF_LAST; // see RULE5 see RULE2
        last_slot_bit = (s.bitn == word_last_bit(s.wide));
        masked        = in_frame_i & {CHANNELS{zero_fill_mask(in_sample_bits_i)}}; // see RULE8
        if (s.div == half_last) begin
            next_s.div = 8'h00;
            next_s.clk = ~s.clk;
            if (s.clk) begin
                // falling edge: marker and data move only here (see RULE10)
                next_s.data   = s.cur[{s.chan, ~s.bitn}]; // see RULE7
                next_s.marker = (s.chan == LAST_CHANNEL) && last_slot_bit; // see RULE6
                if (next_s.marker) begin
                    next_s.chan = FIRST_CHANNEL;
                    next_s.bitn = 5'h00;
                    // an empty buffer sends silence so the frame timing never breaks
                    if (s.head_v) begin
                        next_s.cur       = s.head;
                        next_s.wide      = s.head_wide; // see RULE1
                        next_s.head      = s.skid;
                        next_s.head_wide = s.skid_wide;
                        next_s.head_v    = s.skid_v;
                        next_s.skid_v    = 1'b0;
                    end else begin
                        next_s.cur = '0;
                    end
                end else if (last_slot_bit) begin
                    next_s.bitn = 5'h00;
                    next_s.chan = s.chan + 3'h1; // see RULE3
                end else begin
                    next_s.bitn = s.bitn + 5'h01;
                end
            end
        end else begin
            next_s.div = s.div + 8'h01;
        end
        // slots go out in their places, so mono pairs need nothing here (see RULE4)
        if (take) begin
            if (!next_s.head_v) begin
                next_s.head      = masked;
                next_s.head_wide = in_wide_i;
                next_s.head_v    = 1'b1;
            end else begin
                next_s.skid      = masked;
                next_s.skid_wide = in_wide_i;
                next_s.skid_v    = 1'b1;
            end
        end
        next_s.ready = !next_s.skid_v;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= TX_RESET;
        end else begin
            s <= next_s;
        end
    end

    // all three lines leave straight from flops of this one clock (see RULE12)
    assign link.link_bit_clock    = s.clk;
    assign link.frame_marker      = s.marker;
    assign link.serial_audio_line = s.data;
    assign in_ready_o             = s.ready;

endmodule // audio_link_sender
`default_nettype wire

// [design/audio_link_receiver.sv]
// receiving end: recovers frames, finds the word format and hands frames on
// assumes the link lines are asynchronous to core_clk_i and a link clock
// phase lasts at least two core clock periods
`timescale 1ns/1ns
`default_nettype none
module audio_link_receiver
    import audio_link_pkg::*;
(
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    audio_link_if.receiver             link,
    output logic                       out_valid_o,
    input  wire logic                  out_ready_i,
    output logic [FRAME_BITS-1:0]      out_frame_o,
    output logic                       out_wide_o,
    output logic                       locked_o,
    output logic                       format_wide_o,
    output logic                       align_error_o,
    output logic                       format_change_o,
    output logic                       overflow_o,
    output logic [15:0]                dropped_count_o
);

    typedef struct packed {
        logic [2:0]            sy1;
        logic [2:0]            sy2;
        logic                  prev_clk;
        logic [8:0]            cnt;
        logic                  started;
        logic                  locked;
        logic                  fmt_wide;
        logic [FRAME_BITS-1:0] sr;
        logic [FRAME_BITS-1:0] head;
        logic                  head_wide;
        logic                  head_v;
        logic [FRAME_BITS-1:0] skid;
        logic                  skid_wide;
        logic                  skid_v;
        logic                  align_err;
        logic                  fmt_change;
        logic                  overflow;
        logic [15:0]           dropped;
    } rx_state_t;

    localparam int unsigned SY_CLK    = 2;
    localparam int unsigned SY_MARKER = 1;
    localparam int unsigned SY_DATA   = 0;

    rx_state_t s;
    rx_state_t next_s;

    function automatic logic [15:0] bump(input logic [15:0] v);
        return (v == 16'hFFFF) ? v : v + 16'h0001;
    endfunction

    always_comb begin
        logic                  rise;
        logic                  pop;
        logic                  push;
        logic                  valid_len;
        logic                  len_wide;
        logic [8:0]            cnt1;
        logic [FRAME_BITS-1:0] frame;
        rise              = 1'b0;
        pop               = 1'b0;
        next_s            = s;
        push              = 1'b0;
        valid_len         = 1'b0;
        len_wide          = 1'b0;
        cnt1              = s.cnt;
        frame             = '0;
        next_s.align_err  = 1'b0;
        next_s.fmt_change = 1'b0;
        next_s.overflow   = 1'b0;

        // two flops on each line; only the second stage is looked at
        next_s.sy1      = {link.link_bit_clock, link.frame_marker, link.serial_audio_line};
        next_s.sy2      = s.sy1;
        next_s.prev_clk = s.sy2[SY_CLK];
        rise            = s.sy2[SY_CLK] && !s.prev_clk;

        // drain first so a frame arriving with a pop finds room
        pop = s.head_v && out_ready_i;
        if (pop) begin
            next_s.head      = s.skid;
            next_s.head_wide = s.skid_wide;
            next_s.head_v    = s.skid_v;
            next_s.skid_v    = 1'b0;
        end

        if (rise) begin
            // marker and data taken on the rising edge (see RULE11)
            next_s.sr = {s.sr[FRAME_BITS-2:0], s.sy2[SY_DATA]}; // see RULE7
            cnt1      = (s.cnt == COUNT_SATURATE) ? s.cnt : s.cnt + 9'h001;
            if (s.sy2[SY_MARKER]) begin
                // the marker cycle carries the last bit of channel 7 (see RULE6)
                next_s.cnt     = 9'h000;
                next_s.started = 1'b1;
                valid_len      = (cnt1 == NARROW_FRAME_CLKS) || (cnt1 == WIDE_FRAME_CLKS);
                len_wide       = (cnt1 == WIDE_FRAME_CLKS); // see RULE9
                if (s.started && valid_len) begin
                    next_s.locked     = 1'b1;
                    next_s.fmt_wide   = len_wide; // see RULE9
                    next_s.fmt_change = s.locked && (s.fmt_wide != len_wide);
                    push              = 1'b1;
                    frame             = unpack_frame(next_s.sr, len_wide); // see RULE1 see RULE3
                end else if (s.started) begin
                    // misaligned interval: frame dropped, wait for a good one (see RULE13)
                    next_s.locked    = 1'b0;
                    next_s.align_err = 1'b1;
                    next_s.dropped   = bump(s.dropped);
                end
            end else begin
                next_s.cnt = cnt1;
                // a frame far too long also counts as lost alignment
                if (s.locked && cnt1 > WIDE_FRAME_CLKS) begin // see RULE13
                    next_s.locked    = 1'b0;
                    next_s.align_err = 1'b1;
                    next_s.dropped   = bump(s.dropped);
                end
            end
        end

        // mono pairs are only a meaning of the slots, kept as delivered (see RULE4)
        if (push) begin
            if (!next_s.head_v) begin
                next_s.head      = frame;
                next_s.head_wide = len_wide;
                next_s.head_v    = 1'b1;
            end else if (!next_s.skid_v) begin
                next_s.skid      = frame;
                next_s.skid_wide = len_wide;
                next_s.skid_v    = 1'b1;
            end else begin
                // the link cannot be stalled; a reader stalled two frames loses the newest
                next_s.overflow = 1'b1;
                next_s.dropped  = bump(s.dropped);
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign out_valid_o     = s.head_v;
    assign out_frame_o     = s.head;
    assign out_wide_o      = s.head_wide;
    assign locked_o        = s.locked;
    assign format_wide_o   = s.fmt_wide;
    assign align_error_o   = s.align_err;
    assign format_change_o = s.fmt_change;
    assign overflow_o      = s.overflow;
    assign dropped_count_o = s.dropped;

endmodule // audio_link_receiver
`default_nettype wire

// [tb/audio_link_chk.sv]
// link checker: timing of the three link lines seen from the core clock
// assumes it stands beside the interface that joins sender and receiver
`timescale 1ns/1ns
`default_nettype none
module audio_link_chk
    import audio_link_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic link_bit_clock,
    input  wire logic frame_marker,
    input  wire logic serial_audio_line
);
    logic [8:0] rises;
    logic       seen;
    logic       prev;
    logic       rise_now;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    assign rise_now = link_bit_clock && !prev;
    // counts rises after a marker rise; first marker after reset only starts it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rises <= 9'h000;
            seen  <= 1'b0;
            prev  <= 1'b0;
        end else begin
            prev <= link_bit_clock;
            if (rise_now) begin
                rises <= frame_marker ? 9'h000 : rises + 9'h001;
                seen  <= seen | frame_marker;
            end
        end
    end
    property p_data_fall;
        $changed(serial_audio_line) |-> $fell(link_bit_clock);
    endproperty
    property p_marker_fall;
        $changed(frame_marker) |-> $fell(link_bit_clock);
    endproperty
    property p_rise_stable;
        $rose(link_bit_clock) |-> $stable(frame_marker) && $stable(serial_audio_line);
    endproperty
    property p_marker_len;
        $rose(frame_marker) |->
            frame_marker[*4] ##1 ((!frame_marker) or (frame_marker[*2] ##1 !frame_marker));
    endproperty
    property p_marker_gap;
        $fell(frame_marker) |-> !frame_marker[*8];
    endproperty
    property p_high_half;
        $rose(link_bit_clock) |-> ##[2:3] $fell(link_bit_clock);
    endproperty
    property p_low_half;
        $fell(link_bit_clock) |-> ##[2:3] $rose(link_bit_clock);
    endproperty
    // marker edge not counted, so a frame shows one rise short
    property p_frame_len;
        rise_now && frame_marker && seen |->
            rises == NARROW_FRAME_CLKS - 9'h001 || rises == WIDE_FRAME_CLKS - 9'h001;
    endproperty
    a_data_fall: assert property (p_data_fall) else $error("data moved off falling edge");
    a_marker_fall: assert property (p_marker_fall) else $error("marker off falling edge");
    a_rise_stable: assert property (p_rise_stable) else $error("lines move at rise");
    a_marker_len: assert property (p_marker_len) else $error("marker length wrong");
    a_marker_gap: assert property (p_marker_gap) else $error("marker repeats too soon");
    a_high_half: assert property (p_high_half) else $error("high phase length");
    a_low_half: assert property (p_low_half) else $error("low phase length");
    a_frame_len: assert property (p_frame_len) else $error("frame not 208 or 256");
    c_narrow: cover property (rise_now && frame_marker && seen && rises == 9'h0CF);
    c_wide: cover property (rise_now && frame_marker && seen && rises == 9'h0FF);
    c_data: cover property ($rose(serial_audio_line));
endmodule // audio_link_chk
`default_nettype wire

// [tb/eight_channel_serial_audio_link_tb_top.sv]
// bench: sender and receiver back to back, plus a second receiver fed bench-made frames, good and faulty
// assumes package, interface and both ends are compiled before it
`timescale 1ns/1ns
`default_nettype none
module eight_channel_serial_audio_link_tb_top;
    import audio_link_pkg::*;
    typedef struct packed {logic wide; logic [5:0] bits; logic [31:0] base;} row_t;
    logic                  core_clk_i = 1'b0;
    logic                  rst_n_i    = 1'b0;
    logic                  in_valid   = 1'b0;
    logic                  in_wide    = 1'b0;
    logic [5:0]            in_bits    = 6'h00;
    logic [FRAME_BITS-1:0] in_frame   = '0;
    logic                  rdy        = 1'b1;
    logic                  in_ready, out_valid, out_wide, ovf, locked2, fwide2, aerr2, fchg2;
    logic                  saw_ovf = 1'b0, saw_aerr = 1'b0, saw_fchg = 1'b0;
    logic [FRAME_BITS-1:0] out_frame;
    logic [15:0]           dropped, drop2;
    logic [FRAME_BITS-1:0] got_q [$];
    logic                  gotw_q [$];
    int                    err_count  = 0;
    int                    num_checks = 0;
    // wide and narrow, full and short samples, sign bits set in some slots
    row_t rows [4] = '{'{1'b1, 6'h00, 32'hA5C3_0F81}, '{1'b0, 6'h00, 32'h7E11_2233},
                       '{1'b1, 6'h18, 32'h8123_4567}, '{1'b0, 6'h14, 32'hF0E1_D2C3}};
    audio_link_if lnk ();
    audio_link_if bad ();
    audio_link_sender audio_link_sender_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link(lnk.sender), .in_valid_i(in_valid), .in_ready_o(in_ready),
        .in_frame_i(in_frame), .in_wide_i(in_wide), .in_sample_bits_i(in_bits));
    audio_link_receiver audio_link_receiver_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link(lnk.receiver), .out_valid_o(out_valid), .out_ready_i(rdy),
        .out_frame_o(out_frame), .out_wide_o(out_wide), .locked_o(), .format_wide_o(),
        .align_error_o(), .format_change_o(), .overflow_o(ovf), .dropped_count_o(dropped));
    // second receiver only judges the timing of bench-made frames, good and faulty, so its stall input is tied
    audio_link_receiver audio_link_receiver_i2 (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link(bad.receiver), .out_valid_o(), .out_ready_i(1'b1), .out_frame_o(),
        .out_wide_o(), .locked_o(locked2), .format_wide_o(fwide2), .align_error_o(aerr2),
        .format_change_o(fchg2), .overflow_o(), .dropped_count_o(drop2));
    audio_link_chk audio_link_chk_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link_bit_clock(lnk.link_bit_clock), .frame_marker(lnk.frame_marker),
        .serial_audio_line(lnk.serial_audio_line));
    always #10 core_clk_i = ~core_clk_i;
    // all-zero frames fill idle time, so only nonzero frames are kept
    always @(posedge core_clk_i) begin
        saw_ovf  <= saw_ovf | (ovf === 1'b1);
        saw_aerr <= saw_aerr | (aerr2 === 1'b1);
        saw_fchg <= saw_fchg | (fchg2 === 1'b1);
        if (out_valid === 1'b1 && rdy === 1'b1 && out_frame !== '0) begin
            got_q.push_back(out_frame);
            gotw_q.push_back(out_wide);
        end
    end
    task automatic check(input logic [FRAME_BITS-1:0] seen, input logic [FRAME_BITS-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [FRAME_BITS-1:0] mk(input row_t r, input logic expd);
        logic [FRAME_BITS-1:0] f;
        logic [31:0]           m;
        m = (r.bits != 6'h00 && r.bits < 6'h20) ? ~(32'hFFFFFFFF >> r.bits) : 32'hFFFFFFFF;
        m = r.wide ? m : m & 32'hFFFFFFC0;
        for (int c = 0; c < 8; c++) begin
            f[c*32 +: 32] = (r.base ^ {8{4'(c)}}) & (expd ? m : 32'hFFFFFFFF);
        end
        return f;
    endfunction
    // valid is left high so back-to-back offers never drop it
    task automatic offer(input row_t r);
        int n;
        n = 0;
        in_valid = 1'b1;
        in_frame = mk(r, 1'b0);
        in_wide  = r.wide;
        in_bits  = r.bits;
        while (in_ready !== 1'b1 && n < 5000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic expect_rows(input int a, input int k);
        int n;
        n = 0;
        while (got_q.size() < k && n < 9000) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        for (int i = a; i < a + k; i++) begin
            check(FRAME_BITS'(got_q.size() != 0), FRAME_BITS'(1));
            if (got_q.size() != 0) begin
                check(got_q.pop_front(), mk(rows[i], 1'b1));
                check(FRAME_BITS'(gotw_q.pop_front()), FRAME_BITS'(rows[i].wide));
            end
        end
    endtask
    // link clock from the bench: 160 ns period, marker on the last bit
    task automatic bad_frame(input int len);
        for (int i = 0; i < len; i++) begin
            bad.link_bit_clock    = 1'b0;
            bad.frame_marker      = (i == len - 1);
            bad.serial_audio_line = i[0];
            #80;
            bad.link_bit_clock = 1'b1;
            #80;
        end
    endtask
    initial begin
        #(90_000 * 20);
        err_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        final_report();
    end
    initial begin
        bad.link_bit_clock    = 1'b0;
        bad.frame_marker      = 1'b0;
        bad.serial_audio_line = 1'b0;
        repeat (10) @(posedge core_clk_i);
        #1;
        check(FRAME_BITS'({in_ready, lnk.link_bit_clock, lnk.frame_marker, out_valid}), '0);
        repeat (10) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
        repeat (2) @(posedge lnk.frame_marker);
        @(posedge core_clk_i);
        #1;
        for (int i = 0; i < 4; i++) begin
            offer(rows[i]);
        end
        in_valid = 1'b0;
        expect_rows(0, 4);
        // receiver stalls: the link never waits, so frames must be lost
        rdy = 1'b0;
        repeat (6000) @(posedge core_clk_i);
        #1;
        check(FRAME_BITS'(saw_ovf), FRAME_BITS'(1));
        check(FRAME_BITS'(dropped != 16'h0000), FRAME_BITS'(1));
        rdy = 1'b1;
        @(posedge lnk.frame_marker);
        @(posedge core_clk_i);
        #1;
        offer(rows[0]);
        offer(rows[1]);
        check(FRAME_BITS'(in_ready), '0);
        in_frame = mk(rows[2], 1'b0);
        repeat (5) @(posedge core_clk_i);
        #1;
        in_valid = 1'b0;
        expect_rows(0, 2);
        // a refused frame would show up one frame later, so wait past it
        repeat (2600) @(posedge core_clk_i);
        #1;
        check(FRAME_BITS'(got_q.size()), '0);
        repeat (3) bad_frame(208);
        bad_frame(256);
        bad_frame(100);
        repeat (10) @(posedge core_clk_i);
        #1;
        check(FRAME_BITS'(locked2), '0);
        repeat (2) bad_frame(256);
        repeat (10) @(posedge core_clk_i);
        #1;
        check(FRAME_BITS'({saw_fchg, saw_aerr}), FRAME_BITS'(3));
        check(FRAME_BITS'({locked2, fwide2}), FRAME_BITS'(3));
        check(FRAME_BITS'(drop2 != 16'h0000), FRAME_BITS'(1));
        final_report();
    end
endmodule // eight_channel_serial_audio_link_tb_top
`default_nettype wire
